// ---- vces_status.sv ----
// Event and status register with interrupt mask and DMA control bits.
// Assumes single-cycle register strobes and synchronous event sources.
`timescale 1ns/100ps
`include "vces_cfg.svh"

// Function
// (R1) Writing one clears that event bit; zero bits stay unchanged.
// (R2) All event and status bits readable at any time.
// (R3) Program status set and reset by instruction bits; read-only.
// (R4) Running bit reads zero while the DMA controller is disabled.
// (R5) Ack set on good serial transfer, cleared with done on no-ack.
// (R6) Field bit: zero odd field, one even field.
// (R7) Sync error on end-of-line counter overflow or sync mismatch.
// (R8) Opcode error on reserved opcode, sync status, or instruction error.
// (R9) Bus abort on master or target abort.
// (R10) Fetch parity error sets event and clears DMA program enable.
// (R11) Any bus parity error sets parity event, regardless of response.
// (R12) Stream resync when FIFO counts disagree with the program.
// (R13) Target latency when overrun ends the master transaction.
// (R14) Bus latency while overrun drops double words.
// (R15) Program request when executed instruction asks for interrupt.
// (R16) Pin event on programmed edge or level of the pin.
// (R17) Serial done when a serial read or write finishes.
// (R18) Presence change when analog video appears or disappears.
// (R19) Lock change when horizontal lock changes.
// (R20) Converter overflow on luma or chroma converter overflow.
// (R21) Line start on new analog line or horizontal reset leading edge.
// (R22) Field change on analog or port field change.
// (R23) Format change when a new video standard is detected.
// (R24) Per-bit mask; level interrupt while any unmasked event pends.
// (R25) Pin source optionally inverted; level or rising edge selected.
// (R26) An event in the same cycle as its clear keeps the bit set.
module vces_status
  import vces_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // Register port
  input wire logic [11:0] i_ADDR,
  input wire logic i_RD,
  input wire logic i_WR,
  input wire logic [31:0] i_WDATA,
  output logic [31:0] o_RDATA,
  output logic o_RVALID,
  // Event sources
  input wire vces_pkg::vces_src_t i_SRC,
  input wire vces_pkg::vces_prog_t i_PROG,
  // Interrupt and control
  output logic o_INTA,
  output vces_pkg::vces_ctl_t o_CTL
);
  import vces_pkg::*;

  // ========================================================
  // Address decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  logic wr_stat;
  logic wr_mask;
  logic wr_ctl;
  assign wr_stat = i_WR && hit(i_ADDR, `VCES_OFS_STATUS); // R1
  assign wr_mask = i_WR && hit(i_ADDR, `VCES_OFS_MASK);
  assign wr_ctl = i_WR && hit(i_ADDR, `VCES_OFS_CTL);

  // ========================================================
  // State
  logic [`VCES_EVT_W-1:0] evt_q;
  logic [`VCES_EVT_W-1:0] evt_d;
  logic [`VCES_EVT_W-1:0] mask_q;
  logic [`VCES_EVT_W-1:0] mask_d;
  logic [3:0] pstat_q;
  logic [3:0] pstat_d;
  logic run_q;
  logic ack_q;
  logic ack_d;
  logic field_q;
  vces_ctl_t ctl_q;
  vces_ctl_t ctl_d;
  logic [4:0] prev_q;
  logic primed_q;
  logic [31:0] rdata_d;

  // ========================================================
  // Change and edge detection of level sources
  logic [4:0] lvl_now;
  logic [4:0] lvl_chg;
  assign lvl_now = {i_SRC.horizontal_reset_input, i_SRC.field_port,
                    i_SRC.field_analog, i_SRC.lock_change_event, i_SRC.video_present};
  assign lvl_chg = primed_q ? (lvl_now ^ prev_q) : 5'h00;

  logic hres_edge;
  assign hres_edge = lvl_chg[4] & lvl_now[4]; // R21

  logic pin_evt;
  vces_pin_cond u_pin (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_pin(i_SRC.ext_interrupt_pin),
    .i_invert(ctl_q.pin_invert_select),
    .i_edge(ctl_q.pin_edge_select),
    .o_event(pin_evt)
  );

  logic fetch_perr;
  assign fetch_perr = i_SRC.parity_resp_en & i_SRC.data_parity & i_SRC.fetching; // R10

  // ========================================================
  // Event set vector
  logic [`VCES_EVT_W-1:0] set_raw;
  logic [`VCES_EVT_W-1:0] evt_set;
  logic [`VCES_EVT_W-1:0] evt_clr;
  assign set_raw[23:20] = 4'h0;
  assign set_raw[`VCES_B_SYNC] = i_SRC.sync_eol_ovf | i_SRC.sync_mismatch; // R7
  assign set_raw[`VCES_B_OPC] = i_SRC.op_reserved | i_SRC.sync_stat_reserved
                               | i_SRC.instr_error; // R8
  assign set_raw[`VCES_B_ABORT] = i_SRC.master_abort | i_SRC.target_abort; // R9
  assign set_raw[`VCES_B_FPAR] = fetch_perr; // R10
  assign set_raw[`VCES_B_BPAR] = i_SRC.bus_parity; // R11
  assign set_raw[`VCES_B_RESYNC] = i_SRC.stream_resync; // R12
  assign set_raw[`VCES_B_TLAT] = i_SRC.target_latency; // R13
  assign set_raw[`VCES_B_BLAT] = i_SRC.fifo_drop; // R14
  assign set_raw[`VCES_B_PREQ] = i_SRC.instr_irq; // R15
  assign set_raw[10] = 1'h0;
  assign set_raw[`VCES_B_PIN] = pin_evt; // R16
  assign set_raw[`VCES_B_SDONE] = i_SRC.serial_done; // R17
  assign set_raw[7:6] = 2'h0;
  assign set_raw[`VCES_B_PRES] = lvl_chg[0]; // R18
  assign set_raw[`VCES_B_LOCK] = lvl_chg[1]; // R19
  assign set_raw[`VCES_B_OVF] = i_SRC.luma_ovf | i_SRC.chroma_ovf; // R20
  assign set_raw[`VCES_B_LINE] = i_SRC.line_start | hres_edge; // R21
  assign set_raw[`VCES_B_FLD] = lvl_chg[2] | lvl_chg[3]; // R22
  assign set_raw[`VCES_B_FMT] = i_SRC.format_change; // R23
  assign evt_set = set_raw & `VCES_EVT_IMPL;
  assign evt_clr = wr_stat ? i_WDATA[`VCES_EVT_W-1:0] : `VCES_MASK_RST; // R1

  // ========================================================
  // Sticky event bits, set beats clear
  genvar g;
  generate
    for (g = 0; g < `VCES_EVT_W; g++) begin : g_evt
      assign evt_d[g] = evt_set[g] | (evt_q[g] & ~evt_clr[g]); // R26
      always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
          evt_q[g] <= 1'h0;
        end else begin
          evt_q[g] <= evt_d[g];
        end
      end
    end
  endgenerate

  // ========================================================
  // Live status, mask and control next values
  assign pstat_d = i_PROG.strobe ? ((pstat_q & ~i_PROG.clr) | i_PROG.set) : pstat_q; // R3
  assign ack_d = i_SRC.serial_done ? i_SRC.serial_acked : ack_q; // R5
  assign mask_d = wr_mask ? i_WDATA[`VCES_EVT_W-1:0] : mask_q; // R24
  assign ctl_d.pin_edge_select = wr_ctl ? i_WDATA[`VCES_B_EDGE] : ctl_q.pin_edge_select;
  assign ctl_d.pin_invert_select = wr_ctl ? i_WDATA[`VCES_B_INV] : ctl_q.pin_invert_select;
  assign ctl_d.dma_program_enable = fetch_perr ? 1'h0 : // R10
                                    wr_ctl ? i_WDATA[`VCES_B_DMAEN] : ctl_q.dma_program_enable;

  // ========================================================
  // Read data
  logic [31:0] stat_word;
  assign stat_word = {pstat_q, run_q, 1'h0, ack_q, field_q, evt_q}; // R2
  assign rdata_d = hit(i_ADDR, `VCES_OFS_STATUS) ? stat_word :
                   hit(i_ADDR, `VCES_OFS_MASK) ? {8'h00, mask_q} :
                   hit(i_ADDR, `VCES_OFS_CTL) ? {16'h0000, ctl_q.pin_edge_select,
                     ctl_q.pin_invert_select, 12'h000, ctl_q.dma_program_enable, 1'h0} :
                   32'h00000000;

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      pstat_q <= `VCES_PSTAT_RST;
      ack_q <= 1'h0;
      field_q <= 1'h0;
      run_q <= 1'h0;
      mask_q <= `VCES_MASK_RST;
      ctl_q <= '0;
    end else begin
      pstat_q <= pstat_d;
      ack_q <= ack_d;
      field_q <= i_SRC.field_analog; // R6
      run_q <= ctl_d.dma_program_enable & i_SRC.dma_active; // R4
      mask_q <= mask_d;
      ctl_q <= ctl_d;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      prev_q <= 5'h00;
      primed_q <= 1'h0;
    end else begin
      prev_q <= lvl_now;
      primed_q <= 1'h1;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_RDATA <= 32'h00000000;
      o_RVALID <= 1'h0;
      o_INTA <= 1'h0;
    end else begin
      o_RDATA <= i_RD ? rdata_d : 32'h00000000; // R2
      o_RVALID <= i_RD;
      o_INTA <= |(evt_d & mask_d); // R24
    end
  end

  assign o_CTL = ctl_q;

  // ========================================================
  // Assertions
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  a_clear_hits: assert property ((wr_stat && evt_set == 24'h000000) |=> // R1
    (evt_q & $past(i_WDATA[23:0])) == 24'h000000)
    else $error("written one did not clear event");
  a_clear_keeps: assert property ((wr_stat && evt_set == 24'h000000) |=> // R1
    (evt_q & ~$past(i_WDATA[23:0])) == ($past(evt_q) & ~$past(i_WDATA[23:0])))
    else $error("write disturbed an unselected event");
  a_set_wins: assert property ((evt_set & evt_clr) != 24'h000000 |=> // R26
    (evt_q & $past(evt_set)) == $past(evt_set))
    else $error("event lost against clear");
  a_read_status: assert property ((i_RD && hit(i_ADDR, `VCES_OFS_STATUS)) |=> // R2
    o_RVALID && o_RDATA[23:0] == $past(evt_q) && o_RDATA[31:28] == $past(pstat_q))
    else $error("status read mismatch");
  a_prog_status: assert property (i_PROG.strobe |=> // R3
    (pstat_q & $past(i_PROG.set)) == $past(i_PROG.set) &&
    (pstat_q & $past(i_PROG.clr & ~i_PROG.set)) == 4'h0)
    else $error("program status field wrong");
  a_run_gated: assert property (run_q |-> ctl_q.dma_program_enable) // R4
    else $error("running shown while disabled");
  a_nack_clear: assert property ((i_SRC.serial_done && !i_SRC.serial_acked) |=> // R5
    !ack_q && evt_q[`VCES_B_SDONE])
    else $error("no-ack not shown with done");
  a_fetch_halt: assert property (fetch_perr |=> // R10
    !o_CTL.dma_program_enable && evt_q[`VCES_B_FPAR] && !run_q)
    else $error("fetch parity did not halt DMA");
  a_bus_parity: assert property (i_SRC.bus_parity |=> evt_q[`VCES_B_BPAR]) // R11
    else $error("bus parity event missed");
  a_irq_level: assert property (o_INTA == |(evt_q & mask_q)) // R24
    else $error("interrupt level wrong");
  a_field_change: assert property ((primed_q && $changed(i_SRC.field_port)) |=> // R22
    evt_q[`VCES_B_FLD])
    else $error("field change missed");
  a_sync_error: assert property ((i_SRC.sync_eol_ovf || i_SRC.sync_mismatch) |=> // R7
    evt_q[`VCES_B_SYNC])
    else $error("sync error missed");
  a_opcode_error: assert property ((i_SRC.op_reserved || i_SRC.sync_stat_reserved || // R8
    i_SRC.instr_error) |=> evt_q[`VCES_B_OPC])
    else $error("opcode error missed");
  a_bus_abort: assert property ((i_SRC.master_abort || i_SRC.target_abort) |=> // R9
    evt_q[`VCES_B_ABORT])
    else $error("bus abort missed");
  a_stream_resync: assert property (i_SRC.stream_resync |=> // R12
    evt_q[`VCES_B_RESYNC])
    else $error("stream resync missed");
  a_target_latency: assert property (i_SRC.target_latency |=> // R13
    evt_q[`VCES_B_TLAT])
    else $error("target latency missed");
  a_bus_latency: assert property (i_SRC.fifo_drop |=> // R14
    evt_q[`VCES_B_BLAT])
    else $error("bus latency missed");
  a_prog_request: assert property (i_SRC.instr_irq |=> // R15
    evt_q[`VCES_B_PREQ])
    else $error("program request missed");
  a_pin_level: assert property ((!ctl_q.pin_edge_select && // R16
    (i_SRC.ext_interrupt_pin ^ ctl_q.pin_invert_select)) |=> evt_q[`VCES_B_PIN])
    else $error("pin level event missed");
  a_serial_done: assert property (i_SRC.serial_done |=> // R17
    evt_q[`VCES_B_SDONE])
    else $error("serial done missed");
  a_presence_change: assert property ((primed_q && $changed(i_SRC.video_present)) |=> // R18
    evt_q[`VCES_B_PRES])
    else $error("presence change missed");
  a_lock_change: assert property ((primed_q && $changed(i_SRC.lock_change_event)) |=> // R19
    evt_q[`VCES_B_LOCK])
    else $error("lock change missed");
  a_conv_overflow: assert property ((i_SRC.luma_ovf || i_SRC.chroma_ovf) |=> // R20
    evt_q[`VCES_B_OVF])
    else $error("converter overflow missed");
  a_line_start: assert property ((i_SRC.line_start || // R21
    (primed_q && $rose(i_SRC.horizontal_reset_input))) |=> evt_q[`VCES_B_LINE])
    else $error("line start missed");
  a_format_change: assert property (i_SRC.format_change |=> // R23
    evt_q[`VCES_B_FMT])
    else $error("format change missed");
  a_field_bit: assert property (1'b1 |=> // R6
    field_q == $past(i_SRC.field_analog))
    else $error("field bit does not follow field");
  a_read_idle: assert property (!i_RD |=> // R2
    !o_RVALID && o_RDATA == 32'h00000000)
    else $error("read data shown without a read");

  c_clear_event: cover property (evt_q[`VCES_B_SDONE] ##1 wr_stat ##1 !evt_q[`VCES_B_SDONE]);
  c_irq_unmask: cover property (!o_INTA ##1 wr_mask ##1 o_INTA);
  c_fetch_halt: cover property (o_CTL.dma_program_enable ##1 fetch_perr);
  c_set_clear: cover property ((evt_set & evt_clr) != 24'h000000);
endmodule

// ---- vces_cfg.svh ----
// Constants of the video capture event and status block.
// Assumes byte addresses on a 12-bit register address port.
`ifndef VCES_CFG_SVH
`define VCES_CFG_SVH

// ==========================================================
// Register offsets
`define VCES_OFS_STATUS 12'h100
`define VCES_OFS_MASK 12'h104
`define VCES_OFS_CTL 12'h10C

// ==========================================================
// Status register fields
`define VCES_PSTAT_MSB 31
`define VCES_PSTAT_LSB 28
`define VCES_B_RUN 27
`define VCES_B_ACK 25
`define VCES_B_FIELD 24
`define VCES_B_SYNC 19
`define VCES_B_OPC 18
`define VCES_B_ABORT 17
`define VCES_B_FPAR 16
`define VCES_B_BPAR 15
`define VCES_B_RESYNC 14
`define VCES_B_TLAT 13
`define VCES_B_BLAT 12
`define VCES_B_PREQ 11
`define VCES_B_PIN 9
`define VCES_B_SDONE 8
`define VCES_B_PRES 5
`define VCES_B_LOCK 4
`define VCES_B_OVF 3
`define VCES_B_LINE 2
`define VCES_B_FLD 1
`define VCES_B_FMT 0
`define VCES_EVT_W 24
`define VCES_EVT_IMPL 24'h0FFB3F

// ==========================================================
// Control register fields and reset values
`define VCES_B_EDGE 15
`define VCES_B_INV 14
`define VCES_B_DMAEN 1
`define VCES_MASK_RST 24'h000000
`define VCES_PSTAT_RST 4'h0

`endif

// ---- vces_pkg.sv ----
// Types of the video capture event and status block.
// Assumes nothing beyond a SystemVerilog compiler.
package vces_pkg;

  // ========================================================
  // Event sources, all synchronous to the PCI-side clock
  typedef struct packed {
    logic sync_eol_ovf;
    logic sync_mismatch;
    logic op_reserved;
    logic sync_stat_reserved;
    logic instr_error;
    logic master_abort;
    logic target_abort;
    logic data_parity;
    logic fetching;
    logic parity_resp_en;
    logic bus_parity;
    logic stream_resync;
    logic target_latency;
    logic fifo_drop;
    logic instr_irq;
    logic ext_interrupt_pin;
    logic serial_done;
    logic serial_acked;
    logic video_present;
    logic lock_change_event;
    logic luma_ovf;
    logic chroma_ovf;
    logic line_start;
    logic horizontal_reset_input;
    logic field_analog;
    logic field_port;
    logic format_change;
    logic dma_active;
  } vces_src_t;

  // ========================================================
  // Program status set and reset bits of an executed instruction
  typedef struct packed {
    logic strobe;
    logic [3:0] set;
    logic [3:0] clr;
  } vces_prog_t;

  // ========================================================
  // Control bits held here
  typedef struct packed {
    logic pin_edge_select;
    logic pin_invert_select;
    logic dma_program_enable;
  } vces_ctl_t;

endpackage

// ---- vces_pin_cond.sv ----
// External interrupt pin conditioner: invert, then level or rising edge.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/100ps
module vces_pin_cond (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pin and selects
  input wire logic i_pin,
  input wire logic i_invert,
  input wire logic i_edge,
  // Condition
  output logic o_event
);
  logic lvl;
  logic prev_q;

  assign lvl = i_pin ^ i_invert; // R25
  assign o_event = i_edge ? (lvl & ~prev_q) : lvl; // R25

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_q <= 1'h1;
    end else begin
      prev_q <= lvl;
    end
  end

  a_edge_once: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_edge && o_event) ##1 i_edge |-> !o_event) // R25
    else $error("edge mode gave two events in a row");
endmodule

// ---- vces_host.sv ----
// Host driver model: register reads, writes and read-back clears.
// Assumes one-cycle strobes and a read answer one cycle later.
`timescale 1ns/100ps
`include "vces_cfg.svh"
module vces_host (
  // Clock
  input wire logic i_clk,
  // Register port
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid,
  output logic [11:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata
);
  initial begin
    o_addr = 12'h000;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 32'h00000000;
  end

  // ====================
  // Bus cycles
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_rvalid !== 1'b1 && n < 4);
    d = i_rdata;
  endtask

  // Clear pending events by writing back what was read
  task automatic clr();
    logic [31:0] d;
    rd(`VCES_OFS_STATUS, d);
    wr(`VCES_OFS_STATUS, d);
  endtask
endmodule

// ---- vces_status_tb.sv ----
// Testbench of the video capture event and status block.
// Assumes the host model is the only driver of the register port.
`timescale 1ns/100ps
`include "vces_cfg.svh"
module vces_status_tb;
  import vces_pkg::*;
  localparam logic [11:0] ST = `VCES_OFS_STATUS;
  localparam logic [11:0] MK = `VCES_OFS_MASK;
  localparam logic [11:0] CT = `VCES_OFS_CTL;
  logic clk;
  logic rst;
  logic [11:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rvalid;
  logic inta;
  vces_src_t src;
  vces_src_t hold;
  vces_prog_t prog;
  vces_ctl_t ctl;
  logic [31:0] exp_q[$];
  logic [31:0] r;
  logic [31:0] rv;
  int err_count;
  int checked;
  int cyc;
  int pos[23] = '{27, 26, 25, 24, 23, 22, 21, 17, 16, 15, 14, 13, 12, 11, 9, 8, 7, 6, 5, 4,
    3, 2, 1};
  int bitn[23] = '{19, 19, 18, 18, 18, 17, 17, 15, 14, 13, 12, 11, 9, 8, 5, 4, 3, 3, 2, 2,
    1, 1, 0};

  vces_status dut (.I_CLOCK(clk), .I_RST(rst), .i_ADDR(addr), .i_RD(rd), .i_WR(wr),
    .i_WDATA(wdata), .o_RDATA(rdata), .o_RVALID(rvalid), .i_SRC(src), .i_PROG(prog),
    .o_INTA(inta), .o_CTL(ctl));
  vces_host host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
    .o_rd(rd), .o_wr(wr), .o_wdata(wdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ====================
  // Checking
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("MISMATCH %0t unexpected read answer", $time);
      end else chk(rdata, exp_q.pop_front(), "read data");
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      give_verdict();
    end
  end

  // ====================
  // Stimulus helpers
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.rd(a, r);
  endtask

  task automatic clr_chk(input logic [31:0] e);
    exp_q.push_back(e);
    host.clr();
  endtask

  task automatic pulse(input logic [27:0] m);
    @(posedge clk);
    src <= hold | m;
    @(posedge clk);
    src <= hold;
    repeat (3) @(posedge clk);
  endtask

  task automatic irq(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, inta}, {31'h0, e}, "interrupt level");
  endtask

  task automatic pgm(input logic [3:0] s, input logic [3:0] c);
    @(posedge clk);
    prog <= {1'b1, s, c};
    @(posedge clk);
    prog <= '0;
    @(posedge clk);
  endtask

  initial begin
    rst = 1'b1;
    src = '0;
    hold = '0;
    prog = '0;
    void'($urandom(32'hC849));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ST, 32'h0);
    rd_chk(MK, 32'h0);
    host.wr(12'h108, 32'hFFFFFFFF);
    rd_chk(12'h108, 32'h0);
    host.wr(CT, 32'hFFFFFFFF);
    rd_chk(CT, 32'h0000C002);
    chk({29'h0, ctl}, 32'h7, "control outputs");
    host.wr(CT, 32'h0);
    repeat (3) @(posedge clk);
    host.wr(ST, 32'hFFFFFFFF);
    rd_chk(ST, 32'h0);
    rv = $urandom;
    host.wr(MK, rv);
    rd_chk(MK, {8'h00, rv[23:0]});
    host.wr(MK, 32'h0);
    pulse(28'h1 << 17);
    irq(1'b0);
    host.wr(MK, 32'h8000);
    irq(1'b1);
    host.wr(MK, 32'h00FFFFFF);
    clr_chk(32'h8000);
    irq(1'b0);
    foreach (pos[i]) begin
      pulse(28'h1 << pos[i]);
      irq(1'b1);
      clr_chk(32'h1 << bitn[i]);
      rd_chk(ST, 32'h0);
    end
    hold.field_analog = 1'b1;
    pulse(28'h0);
    clr_chk(32'h01000002);
    hold.field_analog = 1'b0;
    pulse(28'h0);
    clr_chk(32'h2);
    pulse(28'h0020002);
    fork
      host.wr(ST, 32'h8000);
      pulse(28'h1 << 17);
    join
    rd_chk(ST, 32'h8001);
    host.wr(ST, 32'h8000);
    rd_chk(ST, 32'h0001);
    clr_chk(32'h1);
    rv = $urandom_range(15, 1);
    pgm(rv[3:0], 4'h0);
    host.wr(ST, 32'hF0000000);
    rd_chk(ST, {rv[3:0], 28'h0});
    pgm(4'h4, 4'h3);
    rd_chk(ST, {(rv[3:0] & 4'hC) | 4'h4, 28'h0});
    pgm(4'h0, 4'hF);
    rd_chk(ST, 32'h0);
    irq(1'b0);
    pulse(28'hC00);
    clr_chk(32'h02000100);
    rd_chk(ST, 32'h02000000);
    pulse(28'h800);
    clr_chk(32'h100);
    host.wr(CT, 32'h2);
    hold.dma_active = 1'b1;
    pulse(28'h0);
    chk({31'h0, ctl.dma_program_enable}, 32'h1, "dma enable");
    rd_chk(ST, 32'h08000000);
    pulse(28'h180000);
    rd_chk(ST, 32'h08000000);
    pulse(28'h1C0000);
    chk({31'h0, ctl.dma_program_enable}, 32'h0, "dma enable");
    rd_chk(CT, 32'h0);
    clr_chk(32'h00010000);
    hold.dma_active = 1'b0;
    host.wr(CT, 32'h8000);
    hold.ext_interrupt_pin = 1'b1;
    pulse(28'h0);
    clr_chk(32'h200);
    pulse(28'h0);
    rd_chk(ST, 32'h0);
    host.wr(CT, 32'hC000);
    hold.ext_interrupt_pin = 1'b0;
    pulse(28'h0);
    clr_chk(32'h200);
    host.wr(CT, 32'h0);
    repeat (3) @(posedge clk);
    chk(exp_q.size(), 32'h0, "reads left unanswered");
    give_verdict();
  end
endmodule
